// *** hdl/rss_pkg.sv ***
// Constants, codes and types for the run command and speed step selector.
// Assumes one 40 MHz clock domain and contact inputs already synchronous to it.
// Function
// - Nine steps: presets one-eight of the sixteen plus one jog
// - Contact codes 3,4,5,6 select step bits, jog
// - Second analog auxiliary mode: bit1 picks master/auxiliary
// - Step bits form binary index choosing presets one-eight
// - All off selects reference one, the master
// - Jog select overrides step bits
// - Step one uses first analog when source one
// - Step two uses second analog for code 2
// - Step three uses third analog for code 3
// - Run source: keys, terminals, serial, option board
// - Two-wire: forward contact on runs forward
// - Two-wire: reverse contact on runs reverse
// - Two-wire scheme is the default after initialization
// - Contact code 0 enables three-wire, gives direction
// - Three-wire init assigns input three as direction
// - Three-wire latches qualified run pulse internally
// - Reference source: operator, analog, serial, option, pulse
package rss_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RUN_HOLD_MS   = 50;
  localparam int unsigned RUN_HOLD_CYC  = (CLK_HZ / 1000) * RUN_HOLD_MS;
  localparam int unsigned NUM_MF        = 10;
  localparam int unsigned NUM_PRESETS   = 16;
  localparam int unsigned NUM_STEPS     = NUM_PRESETS + 1;
  localparam int unsigned DIR_INPUT_IDX = 2;
  localparam logic [7:0] FN_THREE_WIRE = 8'h00;
  localparam logic [7:0] FN_STEP1      = 8'h03;
  localparam logic [7:0] FN_STEP2      = 8'h04;
  localparam logic [7:0] FN_STEP3      = 8'h05;
  localparam logic [7:0] FN_JOG        = 8'h06;
  localparam logic [7:0] FN_UNUSED_DEF = 8'h0f;
  localparam logic [7:0] AN_AUX_REF    = 8'h02;
  localparam logic [7:0] AN_AUX_REF2   = 8'h03;
  localparam logic [7:0] AN_NOT_USED   = 8'h1f;
  localparam logic [1:0] INIT_TWO_WIRE   = 2'h0;
  localparam logic [1:0] INIT_THREE_WIRE = 2'h1;
  localparam logic [4:0] JOG_IDX       = 5'h10;
  typedef enum logic [1:0] {RSS_RUN_KEYS, RSS_RUN_TERM, RSS_RUN_SERIAL, RSS_RUN_OPTION} rss_run_src_t;
  typedef enum logic [2:0] {RSS_REF_OPER, RSS_REF_ANALOG, RSS_REF_SERIAL, RSS_REF_OPTION, RSS_REF_PULSE}
    rss_ref_src_t;
  localparam rss_run_src_t RUN_SRC_DEFAULT = RSS_RUN_TERM;
  localparam rss_ref_src_t REF_SRC_DEFAULT = RSS_REF_ANALOG;
endpackage

// *** hdl/rss_step_if.sv ***
// Interface carrying decoded contact functions between the top and its helpers.
// Assumes the single system clock; the signals are plain levels.
`timescale 1ns/1ps
`default_nettype none
interface rss_step_if;
  logic       step_bit1;
  logic       step_bit2;
  logic       step_bit3;
  logic       jog_sel;
  logic       three_wire;
  logic       direction_rev;
  modport decoder (output step_bit1, output step_bit2, output step_bit3, output jog_sel,
                   output three_wire, output direction_rev);
  modport user (input step_bit1, input step_bit2, input step_bit3, input jog_sel,
                input three_wire, input direction_rev);
endinterface
`default_nettype wire

// *** hdl/rss_contact_decode.sv ***
// Maps multi-function contacts to step bits, jog, three-wire mode and direction.
// Assumes the function codes are static settings held by the top.
`timescale 1ns/1ps
`default_nettype none
module rss_contact_decode
  import rss_pkg::*;
#(
  parameter int unsigned N = NUM_MF
)(
  input  wire logic [N-1:0]      contact,
  input  wire logic [N*8-1:0]    contact_function_codes,
  rss_step_if.decoder            dec
);
  initial if (N < 3) $error("rss_contact_decode needs at least three inputs");

  // Each function is the OR of all contacts carrying its code; three-wire mode is set by the code alone, whatever the contact.
  always_comb
  begin
    dec.step_bit1     = 1'b0;
    dec.step_bit2     = 1'b0;
    dec.step_bit3     = 1'b0;
    dec.jog_sel       = 1'b0;
    dec.three_wire    = 1'b0;
    dec.direction_rev = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (contact_function_codes[i*8 +: 8] == FN_STEP1) dec.step_bit1 = dec.step_bit1 | contact[i];
      if (contact_function_codes[i*8 +: 8] == FN_STEP2) dec.step_bit2 = dec.step_bit2 | contact[i];
      if (contact_function_codes[i*8 +: 8] == FN_STEP3) dec.step_bit3 = dec.step_bit3 | contact[i];
      if (contact_function_codes[i*8 +: 8] == FN_JOG)   dec.jog_sel   = dec.jog_sel | contact[i];
      if (contact_function_codes[i*8 +: 8] == FN_THREE_WIRE)
      begin
        dec.three_wire    = 1'b1;
        dec.direction_rev = dec.direction_rev | contact[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/rss_run_latch.sv ***
// Three-wire run latch: a run pulse held long enough is kept until stop opens.
// Assumes synchronous contacts; the hold count is a parameter for simulation.
`timescale 1ns/1ps
`default_nettype none
module rss_run_latch
  import rss_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RUN_HOLD_CYC
)(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic run_contact,
  input  wire logic stop_closed,
  output logic      latched
);
  initial if (HOLD_CYC < 1) $error("rss_run_latch needs HOLD_CYC of at least one");

  logic [31:0] hold_cnt;

  // Qualifying counter; a short press is ignored because the host must hold 50 ms.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hold_cnt <= 32'h0;
    else if (!enable || !run_contact || !stop_closed)
      hold_cnt <= 32'h0;
    else if (hold_cnt < HOLD_CYC)
      hold_cnt <= hold_cnt + 32'h1;
  end

  // Self-holding run; an open stop always wins over a run press.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      latched <= 1'b0;
    else if (!enable || !stop_closed)
      latched <= 1'b0;
    else if (hold_cnt + 32'h1 >= HOLD_CYC && run_contact)
      latched <= 1'b1;
  end

  property p_stop_clears;
    @(posedge clk) disable iff (!resetn) (enable && !stop_closed) |=> !latched;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("run latch held with stop open");

  property p_holds;
    @(posedge clk) disable iff (!resetn) (latched && enable && stop_closed) |=> latched;
  endproperty
  a_holds: assert property (p_holds) else $error("run latch dropped without stop");
endmodule
`default_nettype wire

// *** hdl/rss_selector.sv ***
// Top of the run command and speed step selector.
// Contacts, keys and settings are synchronous plain ports; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module rss_selector
  import rss_pkg::*;
#(
  parameter int unsigned W        = 16,
  parameter int unsigned N_MF     = NUM_MF,
  parameter int unsigned HOLD_CYC = RUN_HOLD_CYC
)(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     forward_run_contact,
  input  wire logic                     reverse_stop_contact,
  input  wire logic [N_MF-1:0]          mf_contact,
  input  wire logic [N_MF*8-1:0]        contact_function_codes,
  input  wire logic                     init_strobe,
  input  wire logic [1:0]               init_mode_sel,
  input  wire logic [2:0]               freq_ref_source_sel,
  input  wire logic [1:0]               run_cmd_source_sel,
  input  wire logic [7:0]               second_analog_function,
  input  wire logic [7:0]               third_analog_function,
  input  wire logic [NUM_PRESETS*W-1:0] preset_speeds,
  input  wire logic [W-1:0]             jog_speed_preset,
  input  wire logic [W-1:0]             first_analog_input,
  input  wire logic [W-1:0]             second_analog_input,
  input  wire logic [W-1:0]             third_analog_input,
  input  wire logic [W-1:0]             serial_speed_ref,
  input  wire logic [W-1:0]             option_speed_ref,
  input  wire logic [W-1:0]             pulse_speed_ref,
  input  wire logic                     key_run,
  input  wire logic                     key_reverse,
  input  wire logic                     serial_run,
  input  wire logic                     serial_reverse,
  input  wire logic                     option_run,
  input  wire logic                     option_reverse,
  output logic [W-1:0]                  speed_ref,
  output logic [4:0]                    step_index,
  output logic                          run_cmd,
  output logic                          reverse_cmd,
  output logic                          three_wire_mode,
  output logic [N_MF*8-1:0]             active_function_codes
);
  initial if (W < 1 || N_MF < 3) $error("rss_selector: bad width or contact count");

  // Function codes in force; an init sets the code of input three, the other codes pass through from the settings.
  logic            init_valid;
  logic [1:0]      init_mode;
  logic [N_MF*8-1:0] eff_codes;

  // Initialization mode is captured on a clocked strobe, two-wire after reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      init_valid <= 1'b0;
      init_mode  <= INIT_TWO_WIRE;
    end
    else if (init_strobe)
    begin
      init_valid <= 1'b1;
      init_mode  <= init_mode_sel;
    end
  end

  // Init overrides input three only; other codes follow the settings port.
  always_comb
  begin
    eff_codes = contact_function_codes;
    if (init_valid && init_mode == INIT_THREE_WIRE)
      eff_codes[DIR_INPUT_IDX*8 +: 8] = FN_THREE_WIRE;
    else if (init_valid)
      eff_codes[DIR_INPUT_IDX*8 +: 8] = FN_UNUSED_DEF;
  end

  rss_step_if sif ();

  rss_contact_decode #(.N(N_MF)) u_decode (
    .contact                (mf_contact),
    .contact_function_codes (eff_codes),
    .dec                    (sif.decoder)
  );

  // Run source is terminals in three-wire mode and the stop contact must be closed.
  logic run_latched;
  logic term_sel;
  assign term_sel = (rss_run_src_t'(run_cmd_source_sel) == RSS_RUN_TERM) && sif.three_wire;

  rss_run_latch #(.HOLD_CYC(HOLD_CYC)) u_latch (
    .clk         (clk),
    .resetn      (resetn),
    .enable      (term_sel),
    .run_contact (forward_run_contact),
    .stop_closed (reverse_stop_contact),
    .latched     (run_latched)
  );

  // Step index: jog first, then binary of the three step bits.
  function automatic logic [4:0] pick_index(input logic b1, input logic b2, input logic b3, input logic jog);
    if (jog)
      pick_index = JOG_IDX;
    else
      pick_index = {2'b00, b3, b2, b1};
  endfunction

  logic [4:0]   next_step_index;
  logic [W-1:0] next_speed_ref;
  logic [W-1:0] preset_val;
  logic [W-1:0] step_val;
  logic         aux_mode;

  assign next_step_index = pick_index(sif.step_bit1, sif.step_bit2, sif.step_bit3, sif.jog_sel);
  assign aux_mode        = (second_analog_function == AN_AUX_REF);

  // Preset table lookup; index sixteen selects the jog preset.
  always_comb
  begin
    if (next_step_index == JOG_IDX)
      preset_val = jog_speed_preset;
    else
      preset_val = preset_speeds[next_step_index[3:0]*W +: W];
  end

  // Analog steps replace presets one to three when configured for it.
  always_comb
  begin
    step_val = preset_val;
    if (rss_ref_src_t'(freq_ref_source_sel) == RSS_REF_ANALOG)
    begin
      if (next_step_index == 5'h00)
        step_val = first_analog_input;
      else if (next_step_index == 5'h01 && aux_mode)
        step_val = second_analog_input;
      else if (next_step_index == 5'h02 && third_analog_function == AN_AUX_REF2)
        step_val = third_analog_input;
    end
  end

  // Source routing; multi-step applies to every source, step one taking the serial, option or pulse reference for those sources.
  always_comb
  begin
    case (rss_ref_src_t'(freq_ref_source_sel))
      RSS_REF_OPER:   next_speed_ref = step_val;
      RSS_REF_ANALOG: next_speed_ref = step_val;
      RSS_REF_SERIAL: next_speed_ref = (next_step_index == 5'h00) ? serial_speed_ref : step_val;
      RSS_REF_OPTION: next_speed_ref = (next_step_index == 5'h00) ? option_speed_ref : step_val;
      RSS_REF_PULSE:  next_speed_ref = (next_step_index == 5'h00) ? pulse_speed_ref : step_val;
      default:        next_speed_ref = step_val;
    endcase
  end

  // Registered speed outputs.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      speed_ref  <= '0;
      step_index <= 5'h00;
    end
    else
    begin
      speed_ref  <= next_speed_ref;
      step_index <= next_step_index;
    end
  end

  // Run command routing per source; two-wire with both contacts on stops for safety.
  logic next_run;
  logic next_rev;
  always_comb
  begin
    next_run = 1'b0;
    next_rev = 1'b0;
    case (rss_run_src_t'(run_cmd_source_sel))
      RSS_RUN_KEYS:
      begin
        next_run = key_run;
        next_rev = key_reverse;
      end
      RSS_RUN_TERM:
      begin
        if (sif.three_wire)
        begin
          next_run = run_latched;
          next_rev = sif.direction_rev;
        end
        else
        begin
          next_run = forward_run_contact ^ reverse_stop_contact;
          next_rev = reverse_stop_contact && !forward_run_contact;
        end
      end
      RSS_RUN_SERIAL:
      begin
        next_run = serial_run;
        next_rev = serial_reverse;
      end
      RSS_RUN_OPTION:
      begin
        next_run = option_run;
        next_rev = option_reverse;
      end
      default:
      begin
        next_run = 1'b0;
        next_rev = 1'b0;
      end
    endcase
  end

  // Registered run outputs and mode view.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_cmd               <= 1'b0;
      reverse_cmd           <= 1'b0;
      three_wire_mode       <= 1'b0;
      active_function_codes <= '0;
    end
    else
    begin
      run_cmd               <= next_run;
      reverse_cmd           <= next_rev;
      three_wire_mode       <= sif.three_wire;
      active_function_codes <= eff_codes;
    end
  end

  property p_jog_index;
    @(posedge clk) disable iff (!resetn) sif.jog_sel |=> (step_index == JOG_IDX);
  endproperty
  a_jog_index: assert property (p_jog_index) else $error("jog did not take priority");

  property p_binary_index;
    @(posedge clk) disable iff (!resetn)
      !sif.jog_sel |=> (step_index == {2'b00, $past(sif.step_bit3), $past(sif.step_bit2), $past(sif.step_bit1)});
  endproperty
  a_binary_index: assert property (p_binary_index) else $error("step index not binary of step bits");

  property p_jog_speed;
    @(posedge clk) disable iff (!resetn)
      (sif.jog_sel && rss_ref_src_t'(freq_ref_source_sel) == RSS_REF_OPER) |=> (speed_ref == $past(jog_speed_preset));
  endproperty
  a_jog_speed: assert property (p_jog_speed) else $error("jog speed not selected");

  property p_analog_one;
    @(posedge clk) disable iff (!resetn)
      (next_step_index == 5'h00 && rss_ref_src_t'(freq_ref_source_sel) == RSS_REF_ANALOG)
      |=> (speed_ref == $past(first_analog_input));
  endproperty
  a_analog_one: assert property (p_analog_one) else $error("step one not from first analog");

  property p_analog_two;
    @(posedge clk) disable iff (!resetn)
      (next_step_index == 5'h01 && aux_mode && rss_ref_src_t'(freq_ref_source_sel) == RSS_REF_ANALOG)
      |=> (speed_ref == $past(second_analog_input));
  endproperty
  a_analog_two: assert property (p_analog_two) else $error("step two not from second analog");

  property p_two_wire_fwd;
    @(posedge clk) disable iff (!resetn)
      (rss_run_src_t'(run_cmd_source_sel) == RSS_RUN_TERM && !sif.three_wire && forward_run_contact
       && !reverse_stop_contact) |=> (run_cmd && !reverse_cmd);
  endproperty
  a_two_wire_fwd: assert property (p_two_wire_fwd) else $error("two-wire forward not running");

  property p_two_wire_rev;
    @(posedge clk) disable iff (!resetn)
      (rss_run_src_t'(run_cmd_source_sel) == RSS_RUN_TERM && !sif.three_wire && !forward_run_contact
       && reverse_stop_contact) |=> (run_cmd && reverse_cmd);
  endproperty
  a_two_wire_rev: assert property (p_two_wire_rev) else $error("two-wire reverse not running");

  property p_three_wire_mode;
    @(posedge clk) disable iff (!resetn) (init_valid && init_mode == INIT_THREE_WIRE) |=> three_wire_mode;
  endproperty
  a_three_wire_mode: assert property (p_three_wire_mode) else $error("three-wire init not applied");
endmodule
`default_nettype wire

// *** tb/rss_contact_model.sv ***
// Model of the contact wiring in front of the selector: the run and the reverse/stop contact.
// Assumes the selector's clock; contacts change only a small delay after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rss_contact_model #(
  parameter int unsigned HOLD_CYC = 4
)(
  input  wire logic clk,
  output logic      run_contact,
  output logic      stop_contact
);
  // The contacts rest with run open and stop closed; three-wire reads that as stopped, two-wire terminals as a reverse run.
  initial
  begin
    run_contact  = 1'b0;
    stop_contact = 1'b1;
  end

  // Sets both contacts at once, as a two-position selector switch would.
  task automatic set_pair(input logic fwd, input logic rev);
    @(posedge clk);
    #2;
    run_contact  = fwd;
    stop_contact = rev;
  endtask

  // Closes the run contact for cyc cycles; a legal press lasts HOLD_CYC cycles or more.
  // Shorter presses are only made when the bench asks for a press that must be ignored.
  task automatic press(input int unsigned cyc);
    @(posedge clk);
    #2;
    run_contact = 1'b1;
    repeat (cyc) @(posedge clk);
    #2;
    run_contact = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/rss_selector_tb.sv ***
// Self-checking bench for the run command and speed step selector.
// Assumes the design package and the contact model; the run latch count is cut to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module rss_selector_tb;
  import rss_pkg::*;
  localparam int unsigned W    = 16;
  localparam int unsigned HOLD = 4;
  logic                     clk, resetn, fwd, stop, init_strobe;
  logic [9:0]               mf_contact;
  logic [79:0]              contact_function_codes;
  logic [1:0]               init_mode_sel, run_cmd_source_sel;
  logic [2:0]               freq_ref_source_sel;
  logic [7:0]               second_analog_function, third_analog_function;
  logic [NUM_PRESETS*W-1:0] preset_speeds;
  logic [W-1:0]             jog_speed_preset, first_analog_input, second_analog_input, third_analog_input;
  logic [W-1:0]             serial_speed_ref, option_speed_ref, pulse_speed_ref, speed_ref;
  logic                     key_run, key_reverse, serial_run, serial_reverse, option_run, option_reverse;
  logic [4:0]               step_index;
  logic                     run_cmd, reverse_cmd, three_wire_mode;
  logic [79:0]              active_function_codes;
  logic [5:0]               r;
  int                       err_total, num_checks;

  rss_selector #(.W(W), .N_MF(10), .HOLD_CYC(HOLD)) i_rss_selector (
    .clk, .resetn, .forward_run_contact(fwd), .reverse_stop_contact(stop), .mf_contact,
    .contact_function_codes, .init_strobe, .init_mode_sel, .freq_ref_source_sel, .run_cmd_source_sel,
    .second_analog_function, .third_analog_function, .preset_speeds, .jog_speed_preset,
    .first_analog_input, .second_analog_input, .third_analog_input, .serial_speed_ref,
    .option_speed_ref, .pulse_speed_ref, .key_run, .key_reverse, .serial_run, .serial_reverse,
    .option_run, .option_reverse, .speed_ref, .step_index, .run_cmd, .reverse_cmd,
    .three_wire_mode, .active_function_codes);

  rss_contact_model #(.HOLD_CYC(HOLD)) i_rss_contact_model (.clk(clk), .run_contact(fwd), .stop_contact(stop));

  // Free-running 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Moves a whole number of cycles, landing just after an edge where inputs may change.
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Contact bits {jog, bit3, bit2, bit1}; jog wins over the binary step bits.
  function automatic logic [4:0] exp_idx(input logic [3:0] c);
    return c[3] ? 5'h10 : {2'h0, c[2:0]};
  endfunction

  // Reference expected for a step, from the source selector and the analog functions.
  function automatic logic [W-1:0] exp_speed(input logic [4:0] idx);
    if (idx == 5'h10)
      return jog_speed_preset;
    if (idx == 5'h00 && freq_ref_source_sel != 3'h0)
      case (freq_ref_source_sel)
        3'h1: return first_analog_input;
        3'h2: return serial_speed_ref;
        3'h3: return option_speed_ref;
        default: return pulse_speed_ref;
      endcase
    if (idx == 5'h01 && freq_ref_source_sel == 3'h1 && second_analog_function == 8'h02)
      return second_analog_input;
    if (idx == 5'h02 && freq_ref_source_sel == 3'h1 && third_analog_function == 8'h03)
      return third_analog_input;
    return preset_speeds[idx*W +: W];
  endfunction

  // Applies a step pattern and compares index and reference two edges later.
  task automatic step(input logic [3:0] c);
    mf_contact[5:2] = c;
    tick(2);
    check("step_index", 32'(step_index), 32'(exp_idx(c)));
    check("speed_ref", 32'(speed_ref), 32'(exp_speed(exp_idx(c))));
  endtask

  // A hang is cut short here; every wait below is a fixed count, so this only guards a stall.
  initial
  begin
    #2ms;
    err_total++;
    finish_test();
  end

  initial
  begin
    void'($urandom(68));
    resetn = 1'b0;
    init_strobe = 1'b0;
    init_mode_sel = 2'h0;
    mf_contact = 10'h000;
    contact_function_codes = {10{8'h0f}};
    contact_function_codes[47:16] = 32'h06050403;
    freq_ref_source_sel = 3'h0;
    run_cmd_source_sel = 2'h1;
    second_analog_function = 8'h1f;
    third_analog_function = 8'h1f;
    for (int k = 0; k < NUM_PRESETS; k++)
      preset_speeds[k*W +: W] = 16'($urandom);
    {jog_speed_preset, first_analog_input, second_analog_input} = 48'({$urandom, $urandom});
    {third_analog_input, serial_speed_ref} = 32'($urandom);
    {option_speed_ref, pulse_speed_ref} = 32'($urandom);
    {key_run, key_reverse, serial_run, serial_reverse, option_run, option_reverse} = 6'h00;
    tick(6);
    check("run_cmd", 32'(run_cmd), 32'h0);
    resetn = 1'b1;
    tick(2);
    check("three_wire_mode", 32'(three_wire_mode), 32'h0);
    // Every step pattern, jog over all-on bits included, then random ones.
    for (int c = 0; c < 16; c++)
      step(4'(c));
    repeat (20)
      step(4'($urandom));
    // Analog steps one to three, then analog switched off for steps two and three.
    freq_ref_source_sel = 3'h1;
    second_analog_function = 8'h02;
    third_analog_function = 8'h03;
    for (int c = 0; c < 3; c++)
      step(4'(c));
    second_analog_function = 8'h1f;
    third_analog_function = 8'h1f;
    step(4'h1);
    step(4'h2);
    for (int s = 2; s < 5; s++)
    begin
      freq_ref_source_sel = 3'(s);
      step(4'h0);
    end
    // Run commands from keys, serial link and option board.
    for (int s = 0; s < 4; s++)
      if (s != 1)
        repeat (6)
        begin
          run_cmd_source_sel = 2'(s);
          r = 6'($urandom);
          {option_reverse, option_run, serial_reverse, serial_run, key_reverse, key_run} = r;
          tick(2);
          check("run_cmd", 32'(run_cmd), 32'(r[(s == 0) ? 0 : 2*(s-1)]));
          if (r[(s == 0) ? 0 : 2*(s-1)])
            check("reverse_cmd", 32'(reverse_cmd), 32'(r[(s == 0) ? 1 : 2*(s-1)+1]));
        end
    // Two-wire terminal operation: forward, reverse, both and neither.
    run_cmd_source_sel = 2'h1;
    for (int p = 0; p < 4; p++)
    begin
      i_rss_contact_model.set_pair(p[0], p[1]);
      tick(2);
      check("run_cmd", 32'(run_cmd), 32'(p == 1 || p == 2));
      if (p == 1 || p == 2)
        check("reverse_cmd", 32'(reverse_cmd), 32'(p == 2));
    end
    i_rss_contact_model.set_pair(1'b0, 1'b1);
    // Three-wire: direction on input seven, short press refused, legal press latched.
    contact_function_codes[55:48] = 8'h00;
    mf_contact[6] = 1'b1;
    tick(2);
    check("three_wire_mode", 32'(three_wire_mode), 32'h1);
    i_rss_contact_model.press(HOLD - 1);
    tick(2);
    check("run_cmd", 32'(run_cmd), 32'h0);
    i_rss_contact_model.press(HOLD + 1);
    tick(5);
    check("run_cmd", 32'(run_cmd), 32'h1);
    check("reverse_cmd", 32'(reverse_cmd), 32'h1);
    i_rss_contact_model.set_pair(1'b0, 1'b0);
    tick(2);
    check("run_cmd", 32'(run_cmd), 32'h0);
    i_rss_contact_model.press(HOLD + 1);
    tick(2);
    check("run_cmd", 32'(run_cmd), 32'h0);
    i_rss_contact_model.set_pair(1'b0, 1'b1);
    // Initialisation for three-wire and back: input three becomes the direction input.
    contact_function_codes[55:48] = 8'h0f;
    for (int m = 1; m >= 0; m--)
    begin
      init_mode_sel = 2'(m);
      init_strobe = 1'b1;
      tick(1);
      init_strobe = 1'b0;
      tick(2);
      check("active_code_3", 32'(active_function_codes[23:16]), (m == 1) ? 32'h00 : 32'h0f);
      check("three_wire_mode", 32'(three_wire_mode), 32'(m));
    end
    finish_test();
  end
endmodule
`default_nettype wire
